// file: include/air_pkg.sv
// constants, layouts and types for the interrupt routing and auto-sleep block
package air_pkg;

   // core clock and count-step timing
   localparam int CLK_HZ        = 50_000_000;
   localparam int STEP_SHORT_MS = 320;
   localparam int STEP_LONG_MS  = 640;
   localparam int STEP_SHORT_CYC = STEP_SHORT_MS * (CLK_HZ / 1000);
   localparam int STEP_LONG_CYC  = STEP_LONG_MS * (CLK_HZ / 1000);
   localparam int STEP_CNT_W     = 25;

   // register offsets on the register port
   localparam logic [7:0] ADDR_SLEEP_COUNT = 8'h29;
   localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h2d;
   localparam logic [7:0] ADDR_IRQ_ROUTE   = 8'h2e;

   // reset values
   localparam logic [7:0] RST_SLEEP_COUNT = 8'h00;
   localparam logic [7:0] RST_IRQ_ENABLE  = 8'h00;
   localparam logic [7:0] RST_IRQ_ROUTE   = 8'h00;
   localparam logic [7:0] RD_UNMAPPED     = 8'h00;

   // event source bit positions, shared by enable, routing and event vectors
   localparam int SRC_SLEEP_WAKE  = 7;
   localparam int SRC_BUFFER      = 6;
   localparam int SRC_TRANSIENT   = 5;
   localparam int SRC_ORIENTATION = 4;
   localparam int SRC_TAP         = 3;
   localparam int SRC_FREEFALL    = 2;
   localparam int SRC_VECTOR      = 1;
   localparam int SRC_DATA_READY  = 0;

   // sources that restart the inactivity timer, and those that may wake
   localparam logic [7:0] RESTART_MASK  = 8'h7e;
   localparam logic [7:0] WAKE_CAPABLE  = 8'h3e;
   localparam logic [7:0] DRDY_MASK     = 8'h01;
   localparam int         WAKE_LSB      = 1;

   // active rate code of the slowest rate, which uses the long step
   localparam logic [2:0] RATE_SLOWEST = 3'h7;

   // system mode
   typedef enum logic {
      MODE_ACTIVE,
      MODE_SLEEP
   } air_mode_t;

   // loose configuration bits from the control registers outside
   typedef struct packed {
      logic       sleepEnable;
      logic       irqActiveHigh;
      logic       irqOpenDrain;
      logic       fifoGateEn;
      logic [4:0] wakeEnable;  // transient, orientation, tap, freefall, vector
      logic [2:0] activeSampleRate;
   } air_cfg_t;

   // one interrupt pin: level and output enable
   typedef struct packed {
      logic level;
      logic oe;
   } air_pin_t;

endpackage : air_pkg

// file: logic/air_route_autosleep.sv
// interrupt enable, pin routing, auto-sleep mode control and fifo gate
`timescale 1ns/1ps
module air_route_autosleep
   import air_pkg::*;
#(
   parameter int SHORT_CYC = STEP_SHORT_CYC,
   parameter int LONG_CYC  = STEP_LONG_CYC
)
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // register port
   input  wire logic       regWrEn,
   input  wire logic       regRdEn,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   output logic [7:0]      regRdData,
   // configuration and event detectors
   input  air_cfg_t        cfg,
   input  wire logic [7:0] eventFlags,
   input  wire logic       sleepWakeClear,
   // fifo side
   input  wire logic       fifoEmpty,
   input  wire logic       sampleTick,
   output logic            fifoBlocked,
   output logic            fifoGateError,
   output logic            fifoFlush,
   // mode status and pins
   output logic            asleep,
   output logic            sleepWakeEvent,
   output air_pin_t        firstIrqPin,
   output air_pin_t        secondIrqPin
);

   air_mode_t  mode_ff;
   air_mode_t  nxt_mode;
   logic [7:0] sleepCount_ff;
   logic [7:0] nxt_sleepCount;
   logic [7:0] irqEnable_ff;
   logic [7:0] nxt_irqEnable;
   logic [7:0] irqRoute_ff;
   logic [7:0] nxt_irqRoute;
   logic [7:0] rdData_ff;
   logic [7:0] nxt_rdData;
   logic       swFlag_ff;
   logic       nxt_swFlag;
   logic       blocked_ff;
   logic       nxt_blocked;
   logic       gateErr_ff;
   logic       nxt_gateErr;
   logic       flush_ff;
   logic       nxt_flush;
   logic       firstOn_ff;
   logic       nxt_firstOn;
   logic       secondOn_ff;
   logic       nxt_secondOn;
   logic [7:0] allSrc;
   logic [7:0] enabledSrc;
   logic [7:0] wakeMask;
   logic [7:0] sleepPass;
   logic [7:0] activeSrc;
   logic       restartHit;
   logic       wakeHit;
   logic       timerExpired;
   logic       timerRun;
   logic       changing;
   logic       entering;
   logic       waking;

   // source vector with the internal sleep/wake flag in its slot
   assign allSrc     = {swFlag_ff, eventFlags[SRC_BUFFER:0]};
   assign enabledSrc = allSrc & irqEnable_ff;
   assign wakeMask   = {2'b00, cfg.wakeEnable, 1'b0} & WAKE_CAPABLE;
   // in sleep, wake-capable sources without wake enable and data ready are bypassed
   assign sleepPass  = ~((WAKE_CAPABLE & ~wakeMask) | DRDY_MASK);
   assign activeSrc  = (mode_ff == MODE_SLEEP) ? (enabledSrc & sleepPass) : enabledSrc;

   // qualified restart and wake requests use enabled sources only
   assign restartHit = |(enabledSrc & RESTART_MASK);
   assign wakeHit    = |(enabledSrc & wakeMask);
   assign timerRun   = cfg.sleepEnable && (mode_ff == MODE_ACTIVE);

   // inactivity timer
   air_sleep_timer #(
      .SHORT_CYC (SHORT_CYC),
      .LONG_CYC  (LONG_CYC)
   ) u_timer (
      .core_clk (core_clk),
      .resetn   (resetn),
      .run      (timerRun),
      .restart  (restartHit),
      .longStep (cfg.activeSampleRate == RATE_SLOWEST),
      .limit    (sleepCount_ff),
      .expired  (timerExpired)
   );

   // mode state machine
   always_comb
   begin
      nxt_mode = mode_ff;
      unique case (mode_ff)
         MODE_ACTIVE:
         begin
            if (cfg.sleepEnable && timerExpired)
            begin
               nxt_mode = MODE_SLEEP;
            end
         end
         MODE_SLEEP:
         begin
            if (wakeHit || !cfg.sleepEnable)
            begin
               nxt_mode = MODE_ACTIVE;
            end
         end
      endcase
   end

   assign changing = (nxt_mode != mode_ff);
   assign entering = changing && (nxt_mode == MODE_SLEEP);
   assign waking   = changing && (nxt_mode == MODE_ACTIVE);

   // register writes, read capture, data ready dropped on waking
   always_comb
   begin
      nxt_sleepCount = sleepCount_ff;
      nxt_irqEnable  = irqEnable_ff;
      nxt_irqRoute   = irqRoute_ff;
      nxt_rdData     = rdData_ff;
      if (regWrEn)
      begin
         unique case (regAddr)
            ADDR_SLEEP_COUNT: nxt_sleepCount = regWrData;
            ADDR_IRQ_ENABLE:  nxt_irqEnable  = regWrData;
            ADDR_IRQ_ROUTE:   nxt_irqRoute   = regWrData;
            default:          nxt_rdData     = rdData_ff;
         endcase
      end
      if (waking)
      begin
         nxt_irqEnable = nxt_irqEnable & ~DRDY_MASK;
      end
      if (regRdEn)
      begin
         unique case (regAddr)
            ADDR_SLEEP_COUNT: nxt_rdData = sleepCount_ff;
            ADDR_IRQ_ENABLE:  nxt_rdData = irqEnable_ff;
            ADDR_IRQ_ROUTE:   nxt_rdData = irqRoute_ff;
            default:          nxt_rdData = RD_UNMAPPED;
         endcase
      end
   end

   // sleep/wake flag, fifo gate state and pin levels
   always_comb
   begin
      nxt_swFlag   = changing || (swFlag_ff && !sleepWakeClear);
      nxt_flush    = changing && !cfg.fifoGateEn;
      nxt_blocked  = (changing && cfg.fifoGateEn) || (blocked_ff && !fifoEmpty);
      nxt_gateErr  = (entering && cfg.fifoGateEn)
                  || (blocked_ff && sampleTick && !fifoEmpty)
                  || (gateErr_ff && !fifoEmpty);
      nxt_firstOn  = |(activeSrc & irqRoute_ff);
      nxt_secondOn = |(activeSrc & ~irqRoute_ff);
   end

   // state registers
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         mode_ff       <= MODE_ACTIVE;
         sleepCount_ff <= RST_SLEEP_COUNT;
         irqEnable_ff  <= RST_IRQ_ENABLE;
         irqRoute_ff   <= RST_IRQ_ROUTE;
         rdData_ff     <= RD_UNMAPPED;
         swFlag_ff     <= 1'b0;
         blocked_ff    <= 1'b0;
         gateErr_ff    <= 1'b0;
         flush_ff      <= 1'b0;
         firstOn_ff    <= 1'b0;
         secondOn_ff   <= 1'b0;
      end
      else
      begin
         mode_ff       <= nxt_mode;
         sleepCount_ff <= nxt_sleepCount;
         irqEnable_ff  <= nxt_irqEnable;
         irqRoute_ff   <= nxt_irqRoute;
         rdData_ff     <= nxt_rdData;
         swFlag_ff     <= nxt_swFlag;
         blocked_ff    <= nxt_blocked;
         gateErr_ff    <= nxt_gateErr;
         flush_ff      <= nxt_flush;
         firstOn_ff    <= nxt_firstOn;
         secondOn_ff   <= nxt_secondOn;
      end
   end

   // outputs; pin level follows polarity, open-drain drives only the low level
   assign regRdData          = rdData_ff;
   assign asleep             = (mode_ff == MODE_SLEEP);
   assign sleepWakeEvent     = swFlag_ff;
   assign fifoBlocked        = blocked_ff;
   assign fifoGateError      = gateErr_ff;
   assign fifoFlush          = flush_ff;
   assign firstIrqPin.level  = cfg.irqActiveHigh ? firstOn_ff : ~firstOn_ff;
   assign secondIrqPin.level = cfg.irqActiveHigh ? secondOn_ff : ~secondOn_ff;
   assign firstIrqPin.oe     = cfg.irqOpenDrain ? ~firstIrqPin.level : 1'b1;
   assign secondIrqPin.oe    = cfg.irqOpenDrain ? ~secondIrqPin.level : 1'b1;

   // checks on the behaviour above
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   chk_enable_gate: assert property ((irqEnable_ff == 8'h00) |=> !firstOn_ff && !secondOn_ff)
      else $error("disabled sources reached a pin");
   chk_route_first: assert property ((activeSrc != 8'h00) && ((activeSrc & ~irqRoute_ff) == 8'h00)
      |=> firstOn_ff && !secondOn_ff)
      else $error("routing to first pin wrong");
   chk_or_combine: assert property (($countones(activeSrc & ~irqRoute_ff) >= 2) |=> secondOn_ff)
      else $error("second pin sources not ORed");
   chk_sleep_entry: assert property ((mode_ff == MODE_ACTIVE) && cfg.sleepEnable && timerExpired
      |=> asleep)
      else $error("timeout did not enter sleep");
   chk_sleep_disabled: assert property (!cfg.sleepEnable |=> !asleep)
      else $error("sleep entered while disabled");
   chk_restart_hold: assert property ((mode_ff == MODE_ACTIVE) && restartHit |=> !asleep)
      else $error("restart did not cancel sleep");
   chk_wake_event: assert property ((mode_ff == MODE_SLEEP) && wakeHit |=> !asleep)
      else $error("qualified event did not wake");
   chk_no_false_wake: assert property ((mode_ff == MODE_SLEEP) && cfg.sleepEnable && !wakeHit
      |=> asleep)
      else $error("woke without a wake source");
   chk_transition_flag: assert property ($changed(mode_ff) |-> swFlag_ff)
      else $error("transition did not raise sleep/wake event");
   chk_gate_block: assert property ($rose(asleep) && $past(cfg.fifoGateEn) |-> blocked_ff && gateErr_ff)
      else $error("fifo gate not applied on sleep entry");
   chk_drdy_drop: assert property ($fell(asleep) |-> !irqEnable_ff[SRC_DATA_READY])
      else $error("data ready enable kept after wake");

endmodule : air_route_autosleep

// file: logic/air_sleep_timer.sv
// inactivity timer: count steps of 320 or 640 ms and flag the programmed count
`timescale 1ns/1ps
module air_sleep_timer
   import air_pkg::*;
#(
   parameter int SHORT_CYC = STEP_SHORT_CYC,
   parameter int LONG_CYC  = STEP_LONG_CYC
)
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // control
   input  wire logic       run,
   input  wire logic       restart,
   input  wire logic       longStep,
   input  wire logic [7:0] limit,
   // result
   output logic            expired
);

   logic [STEP_CNT_W-1:0] stepCnt_ff;
   logic [STEP_CNT_W-1:0] nxt_stepCnt;
   logic [STEP_CNT_W-1:0] stepLast;
   logic [7:0]            unitCnt_ff;
   logic [7:0]            nxt_unitCnt;

   // last cycle of one count step at the current rate
   assign stepLast = longStep ? STEP_CNT_W'(LONG_CYC - 1) : STEP_CNT_W'(SHORT_CYC - 1);

   // step prescaler and unit counter, cleared when stopped or restarted
   always_comb
   begin
      nxt_stepCnt = stepCnt_ff;
      nxt_unitCnt = unitCnt_ff;
      if (!run || restart)
      begin
         nxt_stepCnt = '0;
         nxt_unitCnt = '0;
      end
      else if (stepCnt_ff == stepLast)
      begin
         nxt_stepCnt = '0;
         if (unitCnt_ff != 8'hff)
         begin
            nxt_unitCnt = unitCnt_ff + 8'h01;
         end
      end
      else
      begin
         nxt_stepCnt = stepCnt_ff + STEP_CNT_W'(1);
      end
   end

   // counter registers
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stepCnt_ff <= '0;
         unitCnt_ff <= '0;
      end
      else
      begin
         stepCnt_ff <= nxt_stepCnt;
         unitCnt_ff <= nxt_unitCnt;
      end
   end

   // programmed count reached with no restart pending
   assign expired = run && !restart && (unitCnt_ff == limit);

endmodule : air_sleep_timer

// file: sim/air_host_model.sv
// host model: resolves the interrupt lines, reads the source flag, drains the fifo
`timescale 1ns/1ps
module air_host_model
   import air_pkg::*;
#(
   parameter int DRAIN_LAG = 6
)
(
   // clock
   input  wire logic core_clk,
   // device pins and status
   input  air_pin_t  firstIrqPin,
   input  air_pin_t  secondIrqPin,
   input  wire logic irqActiveHigh,
   input  wire logic sleepWakeEvent,
   input  wire logic fifoBlocked,
   input  wire logic fifoFlush,
   input  wire logic sampleTick,
   input  wire logic readSource,
   // host actions and resolved lines
   output logic      firstLine,
   output logic      secondLine,
   output logic      sleepWakeClear,
   output logic      fifoEmpty
);
   int drainCnt = 0;

   // a released open-drain line floats to the pull-up level
   assign firstLine  = firstIrqPin.oe ? firstIrqPin.level : 1'b1;
   assign secondLine = secondIrqPin.oe ? secondIrqPin.level : 1'b1;

   initial sleepWakeClear = 1'b0;
   initial fifoEmpty = 1'b0;

   // host samples on the rising edge and answers through non-blocking updates, so the
   // bench's falling-edge stimulus and the design's outputs never race with it
   always @(posedge core_clk)
   begin
      sleepWakeClear <= readSource && sleepWakeEvent && !sleepWakeClear
                        && (firstLine == irqActiveHigh || secondLine == irqActiveHigh);
      if (fifoBlocked && !fifoEmpty)
         drainCnt <= drainCnt + 1;
      else
         drainCnt <= 0;
      if (drainCnt == DRAIN_LAG || fifoFlush)
         fifoEmpty <= 1'b1;
      else if (sampleTick && !fifoBlocked)
         fifoEmpty <= 1'b0;
   end
endmodule : air_host_model

// file: sim/air_route_autosleep_tb.sv
// testbench for interrupt routing, pin drive and auto-sleep
`timescale 1ns/1ps
module air_route_autosleep_tb;
   import air_pkg::*;
   localparam int SC = 4;
   localparam int LC = 8;
   logic       core_clk   = 1'b0;
   logic       resetn     = 1'b0;
   logic       regWrEn    = 1'b0;
   logic       regRdEn    = 1'b0;
   logic [7:0] regAddr    = 8'h00;
   logic [7:0] regWrData  = 8'h00;
   logic [7:0] eventFlags = 8'h00;
   logic       sampleTick = 1'b0;
   logic       hostRead   = 1'b0;
   air_cfg_t   cfg        = '0;
   logic [7:0] regRdData;
   logic       sleepWakeClear;
   logic       fifoEmpty;
   logic       fifoBlocked;
   logic       fifoGateError;
   logic       fifoFlush;
   logic       asleep;
   logic       sleepWakeEvent;
   logic       firstLine;
   logic       secondLine;
   air_pin_t   firstIrqPin;
   air_pin_t   secondIrqPin;
   logic [7:0] d;
   int         n;
   int         fails = 0;
   int         samplesChecked = 0;

   // 50 MHz core clock
   always #10 core_clk = ~core_clk;

   air_route_autosleep #(.SHORT_CYC(SC), .LONG_CYC(LC)) i_dut (
      .core_clk(core_clk), .resetn(resetn), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .cfg(cfg),
      .eventFlags(eventFlags), .sleepWakeClear(sleepWakeClear), .fifoEmpty(fifoEmpty),
      .sampleTick(sampleTick), .fifoBlocked(fifoBlocked), .fifoGateError(fifoGateError),
      .fifoFlush(fifoFlush), .asleep(asleep), .sleepWakeEvent(sleepWakeEvent),
      .firstIrqPin(firstIrqPin), .secondIrqPin(secondIrqPin));

   air_host_model #(.DRAIN_LAG(6)) i_host (
      .core_clk(core_clk), .firstIrqPin(firstIrqPin), .secondIrqPin(secondIrqPin),
      .irqActiveHigh(cfg.irqActiveHigh), .sleepWakeEvent(sleepWakeEvent),
      .fifoBlocked(fifoBlocked), .fifoFlush(fifoFlush), .sampleTick(sampleTick),
      .readSource(hostRead), .firstLine(firstLine), .secondLine(secondLine),
      .sleepWakeClear(sleepWakeClear), .fifoEmpty(fifoEmpty));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      begin
         samplesChecked++;
         if (got !== exp)
         begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask : chk

   task automatic ticks(input int k);
      begin
         repeat (k) @(negedge core_clk);
      end
   endtask : ticks

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      begin
         @(negedge core_clk);
         regWrEn = 1'b1;
         regAddr = a;
         regWrData = v;
         @(negedge core_clk);
         regWrEn = 1'b0;
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      begin
         @(negedge core_clk);
         regRdEn = 1'b1;
         regAddr = a;
         @(negedge core_clk);
         regRdEn = 1'b0;
         @(negedge core_clk);
         v = regRdData;
      end
   endtask : rd

   // cycles until sleep is entered, bounded
   task automatic sleepTime(output int k);
      begin
         k = 0;
         while (asleep !== 1'b1 && k < 100)
         begin
            @(negedge core_clk);
            k++;
         end
      end
   endtask : sleepTime

   function automatic logic [7:0] lines();
      return {6'h00, firstLine, secondLine};
   endfunction : lines

   function automatic logic [7:0] inWin(input int k, input int lo);
      return {7'h00, k >= lo && k <= lo + 3};
   endfunction : inWin

   task automatic test_done;
      begin
         $display("checked %0d, failed %0d", samplesChecked, fails);
         if (fails == 0 && samplesChecked > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask : test_done

   // watchdog against a hung sequence
   initial
   begin
      #100000;
      fails++;
      test_done();
   end

   // main sequence
   initial
   begin
      #80 resetn = 1'b1;
      rd(ADDR_IRQ_ENABLE, d);
      chk(d, 8'h00);
      rd(ADDR_IRQ_ROUTE, d);
      chk(d, 8'h00);
      rd(ADDR_SLEEP_COUNT, d);
      chk(d, 8'h00);
      wr(8'h30, 8'hff);
      rd(8'h30, d);
      chk(d, 8'h00);
      cfg.irqActiveHigh = 1'b1;
      wr(ADDR_IRQ_ENABLE, 8'h7f);
      // each source except sleep/wake to each pin
      for (int i = 0; i < 7; i++)
      begin
         wr(ADDR_IRQ_ROUTE, 8'h01 << i);
         eventFlags = 8'h01 << i;
         ticks(2);
         chk(lines(), 8'h02);
         wr(ADDR_IRQ_ROUTE, 8'h00);
         ticks(2);
         chk(lines(), 8'h01);
      end
      wr(ADDR_IRQ_ENABLE, 8'h00);
      eventFlags = 8'hff;
      ticks(2);
      chk(lines(), 8'h00);
      wr(ADDR_IRQ_ENABLE, 8'h0c);
      wr(ADDR_IRQ_ROUTE, 8'h0c);
      eventFlags = 8'h0c;
      ticks(2);
      chk(lines(), 8'h02);
      eventFlags = 8'h04;
      ticks(2);
      chk(lines(), 8'h02);
      // two sources ORed on the second pin
      wr(ADDR_IRQ_ROUTE, 8'h00);
      eventFlags = 8'h0c;
      ticks(2);
      chk(lines(), 8'h01);
      wr(ADDR_IRQ_ROUTE, 8'h0c);
      eventFlags = 8'h00;
      cfg.irqActiveHigh = 1'b0;
      ticks(2);
      chk({4'h0, firstIrqPin, secondIrqPin}, 8'h0f);
      cfg.irqOpenDrain = 1'b1;
      eventFlags = 8'h04;
      ticks(2);
      chk({4'h0, firstIrqPin, secondIrqPin}, 8'h06);
      chk(lines(), 8'h01);
      eventFlags = 8'h00;
      cfg.irqActiveHigh = 1'b1;
      cfg.irqOpenDrain = 1'b0;
      // auto-sleep with a disabled source held active
      wr(ADDR_IRQ_ROUTE, 8'h80);
      wr(ADDR_SLEEP_COUNT, 8'h02);
      wr(ADDR_IRQ_ENABLE, 8'hc5);
      cfg.wakeEnable = 5'b00010;
      eventFlags = 8'h08;
      cfg.sleepEnable = 1'b1;
      sleepTime(n);
      chk(inWin(n, 2 * SC), 8'h01);
      ticks(1);
      chk({7'h00, sleepWakeEvent}, 8'h01);
      chk(lines(), 8'h02);
      hostRead = 1'b1;
      ticks(3);
      hostRead = 1'b0;
      chk({7'h00, sleepWakeEvent}, 8'h00);
      eventFlags = 8'h48;
      ticks(6);
      chk({7'h00, asleep}, 8'h01);
      eventFlags = 8'h04;
      ticks(3);
      chk({6'h00, asleep, sleepWakeEvent}, 8'h01);
      rd(ADDR_IRQ_ENABLE, d);
      chk(d, 8'hc4);
      ticks(12);
      chk({7'h00, asleep}, 8'h00);
      // restart in mid count
      eventFlags = 8'h00;
      ticks(5);
      eventFlags = 8'h40;
      ticks(1);
      eventFlags = 8'h00;
      sleepTime(n);
      chk(inWin(n, 2 * SC), 8'h01);
      // slowest rate uses the long step
      cfg.sleepEnable = 1'b0;
      ticks(1);
      chk({6'h00, asleep, fifoFlush}, 8'h01);
      ticks(1);
      chk({7'h00, asleep}, 8'h00);
      wr(ADDR_SLEEP_COUNT, 8'h01);
      cfg.activeSampleRate = 3'h7;
      cfg.sleepEnable = 1'b1;
      sleepTime(n);
      chk(inWin(n, LC), 8'h01);
      // fifo gate on entering sleep
      cfg.sleepEnable = 1'b0;
      ticks(2);
      sampleTick = 1'b1;
      ticks(1);
      sampleTick = 1'b0;
      cfg.fifoGateEn = 1'b1;
      cfg.sleepEnable = 1'b1;
      sleepTime(n);
      ticks(1);
      chk({5'h00, fifoBlocked, fifoGateError, asleep}, 8'h07);
      sampleTick = 1'b1;
      ticks(1);
      sampleTick = 1'b0;
      ticks(1);
      chk({5'h00, fifoBlocked, fifoGateError, asleep}, 8'h07);
      ticks(12);
      chk({5'h00, fifoBlocked, fifoGateError, asleep}, 8'h01);
      test_done();
   end
endmodule : air_route_autosleep_tb
